// >>> rtl/autoneg_pkg.sv
// package: offsets, reset values, field layouts and carrier types of the page registers
package autoneg_pkg;

   // ------------------------------------------------------------
   // register offsets (management register address)
   // ------------------------------------------------------------
   localparam logic [15:0] OFF_PARTNER_LOW = 16'h0013;
   localparam logic [15:0] OFF_PARTNER_MID = 16'h0014;
   localparam logic [15:0] OFF_PARTNER_HIGH = 16'h0015;
   localparam logic [15:0] OFF_NP_LOW = 16'h0016;
   localparam logic [15:0] OFF_NP_MID = 16'h0017;
   localparam logic [15:0] OFF_NP_HIGH = 16'h0018;

   // ------------------------------------------------------------
   // reset values and fixed read values
   // ------------------------------------------------------------
   localparam logic [47:0] RST_PARTNER_PAGE = 48'h0000_0000_0000;
   localparam logic [15:0] RST_SNAP_WORD = 16'h0000;
   localparam logic [15:0] RST_NP_LOW = 16'h2000;
   localparam logic [15:0] RST_NP_MID = 16'h0000;
   localparam logic [15:0] RST_NP_HIGH = 16'h0000;
   localparam logic RST_TOGGLE = 1'h0;
   localparam logic [15:0] RST_RDATA = 16'h0000;
   localparam logic [15:0] UNMAPPED_RDATA = 16'h0000;
   localparam logic [4:0] SELECTOR_VALUE = 5'h01;
   localparam logic [15:0] NP_LOW_WMASK = 16'hBFFF;

   // ------------------------------------------------------------
   // field positions inside a 48-bit codeword
   // ------------------------------------------------------------
   localparam int unsigned POS_TOGGLE = 11;
   localparam int unsigned WORD_MID_LSB = 16;
   localparam int unsigned WORD_HIGH_LSB = 32;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } reg_resp_t;

   typedef struct packed {
      logic valid;
      logic [47:0] word;
   } rx_page_t;

   // partner base page, word at 0x0013
   typedef struct packed {
      logic partner_more_pages;
      logic partner_ack_bit;
      logic partner_fault_flag;
      logic [2:0] partner_pause_abilities;
      logic [4:0] partner_echoed_random;
      logic [4:0] partner_protocol_select;
   } partner_low_t;

   // partner base page, word at 0x0014
   typedef struct packed {
      logic [7:0] partner_tech_bits_mid;
      logic partner_kr_capable;
      logic partner_tech_bit_one;
      logic partner_kx_capable;
      logic [4:0] partner_sent_random;
   } partner_mid_t;

   // partner base page, word at 0x0015
   typedef struct packed {
      logic partner_wants_correction;
      logic partner_can_correct;
      logic [13:0] partner_tech_bits_high;
   } partner_high_t;

   // next page to send, word at 0x0016
   typedef struct packed {
      logic more_pages_out;
      logic reserved_zero;
      logic message_page_flag;
      logic can_comply_flag;
      logic alternating_page_bit;
      logic [10:0] page_code_low;
   } np_low_t;

   typedef struct packed {
      logic [47:0] page;
   } store_state_t;

   typedef struct packed {
      np_low_t np_low;
      logic [15:0] page_code_mid;
      logic [15:0] page_code_high;
      logic toggle;
      logic [15:0] snap_mid;
      logic [15:0] snap_high;
      reg_resp_t resp;
      logic [47:0] tx_page;
   } bank_state_t;

endpackage

// >>> rtl/partner_page_store.sv
// module: holder of the last base page received from the link partner
`timescale 1ns/100ps
`default_nettype none

module partner_page_store (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire autoneg_pkg::rx_page_t i_capture,
   output logic [47:0] o_page
);

   autoneg_pkg::store_state_t s_r;
   autoneg_pkg::store_state_t s_nxt;

   // ------------------------------------------------------------
   // capture
   // ------------------------------------------------------------
   // the whole page is written in one edge, so a reader never sees halves
   always_comb begin
      s_nxt = s_r;
      if (i_capture.valid) begin
         s_nxt.page = i_capture.word;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_r.page <= autoneg_pkg::RST_PARTNER_PAGE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_page = s_r.page;

endmodule
`default_nettype wire

// >>> rtl/autoneg_page_registers.sv
// module: partner base page capture and next-page transmit registers
//
// Contract
// (R1) low word bit 15: partner next-page bit
// (R2) low word bit 14: partner ack, read-only
// (R3) low word bit 13: partner remote fault
// (R4) low word bits 12:10: partner pause abilities
// (R5) low word bits 9:5: partner echoed nonce
// (R6) low word bits 4:0 always read 00001
// (R7) software reads low word before mid, high
// (R8) low word read latches mid and high
// (R9) mid word bits 15:8: ability bits 10:3
// (R10) mid word bit 7: partner KR capable
// (R11) mid bit 5 KX, bit 6 raw D22
// (R12) mid word bits 4:0: partner sent nonce
// (R13) high word bit 15: partner requests FEC
// (R14) high word bit 14: partner FEC capable
// (R15) high word bits 13:0: ability bits 24:11
// (R16) writes to partner words are ignored
// (R17) next-page bit 15, RW, resets 0
// (R18) message page bit 13, RW, resets 1
// (R19) can-comply bit 12, RW, resets 0
// (R20) toggle made in hardware, bit 11 stored only
// (R21) code field bits 10:0, RW, reset 0
// (R22) second transmit word sends D31:D16
// (R23) third transmit word sends D47:D32
`timescale 1ns/100ps
`default_nettype none

module autoneg_page_registers (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire autoneg_pkg::reg_req_t i_reg_req,
   output autoneg_pkg::reg_resp_t o_reg_resp,
   input wire autoneg_pkg::rx_page_t i_rx_page,
   input wire logic i_np_begin,
   input wire logic i_np_first_toggle,
   input wire logic i_np_sent,
   output logic [47:0] o_tx_page
);

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] off);
      addr_hit = (addr == off);
   endfunction

   function automatic logic partner_word(input logic [15:0] addr);
      partner_word = addr_hit(addr, autoneg_pkg::OFF_PARTNER_LOW) ||
                     addr_hit(addr, autoneg_pkg::OFF_PARTNER_MID) ||
                     addr_hit(addr, autoneg_pkg::OFF_PARTNER_HIGH);
   endfunction

   // ------------------------------------------------------------
   // field views of the received page
   // ------------------------------------------------------------
   function automatic autoneg_pkg::partner_low_t view_low(input logic [47:0] pg);
      autoneg_pkg::partner_low_t v;
      v.partner_more_pages = pg[15]; // see (R1)
      v.partner_ack_bit = pg[14]; // see (R2)
      v.partner_fault_flag = pg[13]; // see (R3)
      v.partner_pause_abilities = pg[12:10]; // see (R4)
      v.partner_echoed_random = pg[9:5]; // see (R5)
      // the selector is fixed by the protocol, so the received bits are not shown
      v.partner_protocol_select = autoneg_pkg::SELECTOR_VALUE; // see (R6)
      view_low = v;
   endfunction

   function automatic autoneg_pkg::partner_mid_t view_mid(input logic [47:0] pg);
      autoneg_pkg::partner_mid_t v;
      v.partner_tech_bits_mid = pg[31:24]; // see (R9)
      v.partner_kr_capable = pg[23]; // see (R10)
      v.partner_tech_bit_one = pg[22]; // see (R11)
      v.partner_kx_capable = pg[21]; // see (R11)
      v.partner_sent_random = pg[20:16]; // see (R12)
      view_mid = v;
   endfunction

   function automatic autoneg_pkg::partner_high_t view_high(input logic [47:0] pg);
      autoneg_pkg::partner_high_t v;
      v.partner_wants_correction = pg[47]; // see (R13)
      v.partner_can_correct = pg[46]; // see (R14)
      v.partner_tech_bits_high = pg[45:32]; // see (R15)
      view_high = v;
   endfunction

   // ------------------------------------------------------------
   // received page store
   // ------------------------------------------------------------
   logic [47:0] partner_page;

   partner_page_store u_store (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_capture(i_rx_page),
      .o_page(partner_page)
   );

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   autoneg_pkg::bank_state_t s_r;
   autoneg_pkg::bank_state_t s_nxt;
   autoneg_pkg::partner_mid_t mid_now;
   autoneg_pkg::partner_high_t high_now;
   logic [15:0] low_now;
   logic [15:0] np_low_word;
   logic [15:0] np_low_written;

   assign low_now = view_low(partner_page);
   assign mid_now = view_mid(partner_page);
   assign high_now = view_high(partner_page);
   assign np_low_word = s_r.np_low;
   // reserved bit 14 is dropped on the way in, so it always reads 0
   assign np_low_written = i_reg_req.wdata & autoneg_pkg::NP_LOW_WMASK;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.resp.valid = 1'b0;

      // register writes; partner words are not decoded here
      if (i_reg_req.wr) begin
         case (i_reg_req.addr)
            autoneg_pkg::OFF_NP_LOW: begin
               s_nxt.np_low = np_low_written; // see (R17) (R18) (R19) (R21)
            end
            autoneg_pkg::OFF_NP_MID: begin
               s_nxt.page_code_mid = i_reg_req.wdata; // see (R22)
            end
            autoneg_pkg::OFF_NP_HIGH: begin
               s_nxt.page_code_high = i_reg_req.wdata; // see (R23)
            end
            default: begin
               // partner words and unmapped addresses: dropped silently
               s_nxt.np_low = s_r.np_low; // see (R16)
            end
         endcase
      end

      // hardware toggle: seeded when a next-page exchange starts,
      // flipped after each page the engine has sent
      if (i_np_begin) begin
         s_nxt.toggle = i_np_first_toggle; // see (R20)
      end else if (i_np_sent) begin
         s_nxt.toggle = ~s_r.toggle; // see (R20)
      end

      // register reads; the answer is the value before any write this cycle
      if (i_reg_req.rd) begin
         s_nxt.resp.valid = 1'b1;
         case (i_reg_req.addr)
            autoneg_pkg::OFF_PARTNER_LOW: begin
               s_nxt.resp.data = low_now;
               // freeze the rest of this same page for the reads that follow
               s_nxt.snap_mid = mid_now; // see (R8) (R7)
               s_nxt.snap_high = high_now; // see (R8) (R7)
            end
            autoneg_pkg::OFF_PARTNER_MID: begin
               s_nxt.resp.data = s_r.snap_mid; // see (R8)
            end
            autoneg_pkg::OFF_PARTNER_HIGH: begin
               s_nxt.resp.data = s_r.snap_high; // see (R8)
            end
            autoneg_pkg::OFF_NP_LOW: begin
               // bit 11 gives back what was written, not the live toggle
               s_nxt.resp.data = np_low_word; // see (R20)
            end
            autoneg_pkg::OFF_NP_MID: begin
               s_nxt.resp.data = s_r.page_code_mid;
            end
            autoneg_pkg::OFF_NP_HIGH: begin
               s_nxt.resp.data = s_r.page_code_high;
            end
            default: begin
               s_nxt.resp.data = autoneg_pkg::UNMAPPED_RDATA;
            end
         endcase
      end

      // codeword offered to the engine, built from the values being stored
      s_nxt.tx_page = {s_nxt.page_code_high, s_nxt.page_code_mid, s_nxt.np_low}; // see (R22) (R23)
      s_nxt.tx_page[autoneg_pkg::POS_TOGGLE] = s_nxt.toggle; // see (R20)
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_r.np_low <= autoneg_pkg::RST_NP_LOW; // see (R17) (R18) (R19) (R21)
         s_r.page_code_mid <= autoneg_pkg::RST_NP_MID;
         s_r.page_code_high <= autoneg_pkg::RST_NP_HIGH;
         s_r.toggle <= autoneg_pkg::RST_TOGGLE;
         s_r.snap_mid <= autoneg_pkg::RST_SNAP_WORD;
         s_r.snap_high <= autoneg_pkg::RST_SNAP_WORD;
         s_r.resp.valid <= 1'b0;
         s_r.resp.data <= autoneg_pkg::RST_RDATA;
         s_r.tx_page <= {autoneg_pkg::RST_NP_HIGH, autoneg_pkg::RST_NP_MID, autoneg_pkg::RST_NP_LOW};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_reg_resp = s_r.resp;
   assign o_tx_page = s_r.tx_page;

endmodule
`default_nettype wire

// >>> tb/autoneg_page_registers_chk.sv
// checker: port assertions for the page register bank
`timescale 1ns/100ps
`default_nettype none
module autoneg_page_registers_chk (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire autoneg_pkg::reg_req_t i_reg_req,
   input wire autoneg_pkg::reg_resp_t o_reg_resp,
   input wire autoneg_pkg::rx_page_t i_rx_page,
   input wire logic i_np_begin,
   input wire logic i_np_first_toggle,
   input wire logic i_np_sent,
   input wire logic [47:0] o_tx_page
);
   logic [47:0] pg_r;
   logic [31:0] sn_r;
   wire logic [15:0] wd = i_reg_req.wdata;
   wire logic rd_lo = i_reg_req.rd && i_reg_req.addr == autoneg_pkg::OFF_PARTNER_LOW;
   wire logic rd_mid = i_reg_req.rd && i_reg_req.addr == autoneg_pkg::OFF_PARTNER_MID;
   wire logic rd_hi = i_reg_req.rd && i_reg_req.addr == autoneg_pkg::OFF_PARTNER_HIGH;
   wire logic wr_nl = i_reg_req.wr && i_reg_req.addr == autoneg_pkg::OFF_NP_LOW;
   wire logic wr_nm = i_reg_req.wr && i_reg_req.addr == autoneg_pkg::OFF_NP_MID;
   wire logic wr_nh = i_reg_req.wr && i_reg_req.addr == autoneg_pkg::OFF_NP_HIGH;
   // shadow of the captured page; snapshot taken from the old page on a low read
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         pg_r <= '0;
         sn_r <= '0;
      end else begin
         if (i_rx_page.valid) pg_r <= i_rx_page.word;
         if (rd_lo) sn_r <= pg_r[47:16];
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   property p_low_flags; rd_lo |=> o_reg_resp.data[15:13] == $past(pg_r[15:13]); endproperty
   a_low_flags: assert property (p_low_flags) else $error("low word flags wrong");
   property p_low_fields; rd_lo |=> o_reg_resp.data[12:5] == $past(pg_r[12:5]); endproperty
   a_low_fields: assert property (p_low_fields) else $error("low word fields wrong");
   property p_sel; rd_lo |=> o_reg_resp.valid && o_reg_resp.data[4:0] == 5'h01; endproperty
   a_sel: assert property (p_sel) else $error("selector wrong");
   property p_mid; rd_mid |=> o_reg_resp.data == $past(sn_r[15:0]); endproperty
   a_mid: assert property (p_mid) else $error("mid word wrong");
   property p_high; rd_hi |=> o_reg_resp.data == $past(sn_r[31:16]); endproperty
   a_high: assert property (p_high) else $error("high word wrong");
   property p_np_low; wr_nl |=> (o_tx_page[15:0] & 16'hF7FF) == ($past(wd) & 16'hB7FF); endproperty
   a_np_low: assert property (p_np_low) else $error("sent low word wrong");
   property p_np_mid; wr_nm |=> o_tx_page[31:16] == $past(wd); endproperty
   a_np_mid: assert property (p_np_mid) else $error("sent mid word wrong");
   property p_np_high; wr_nh |=> o_tx_page[47:32] == $past(wd); endproperty
   a_np_high: assert property (p_np_high) else $error("sent high word wrong");
   property p_seed; i_np_begin |=> o_tx_page[11] == $past(i_np_first_toggle); endproperty
   a_seed: assert property (p_seed) else $error("toggle seed wrong");
   property p_flip; i_np_sent && !i_np_begin |=> o_tx_page[11] != $past(o_tx_page[11]); endproperty
   a_flip: assert property (p_flip) else $error("toggle did not flip");
endmodule
bind autoneg_page_registers autoneg_page_registers_chk i_chk (.i_core_clk, .i_rst, .i_reg_req, .o_reg_resp,
   .i_rx_page, .i_np_begin, .i_np_first_toggle, .i_np_sent, .o_tx_page);
`default_nettype wire

// >>> tb/mgmt_host.sv
// model: management host on the register request port
`timescale 1ns/100ps
`default_nettype none
module mgmt_host (
   input wire logic i_core_clk,
   input wire autoneg_pkg::reg_resp_t i_resp,
   output autoneg_pkg::reg_req_t o_req
);
   initial o_req = '{rd: 1'b0, wr: 1'b0, addr: 16'hA5A5, wdata: 16'h5A5A};
   // idle fields flip so stale values never look valid
   task automatic idle();
      o_req = '{rd: 1'b0, wr: 1'b0, addr: ~o_req.addr, wdata: ~o_req.wdata};
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      @(negedge i_core_clk);
      o_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge i_core_clk);
      idle();
   endtask
   task automatic rd_reg(input logic [15:0] a, output logic [15:0] d, output logic ok);
      @(negedge i_core_clk);
      o_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~o_req.wdata};
      @(negedge i_core_clk);
      idle();
      ok = i_resp.valid === 1'b1;
      d = i_resp.data;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_autoneg_page_registers.sv
// testbench: random and corner traffic through the page register bank
`timescale 1ns/100ps
`default_nettype none
module tb_autoneg_page_registers;
   logic clk, rst, nb, nf, ns, ok, tog;
   autoneg_pkg::reg_req_t req;
   autoneg_pkg::reg_resp_t resp;
   autoneg_pkg::rx_page_t rx;
   logic [47:0] tx, w;
   logic [15:0] d, n0, n1, n2;
   integer seed = 32'hcb73;
   integer num_errors = 0;
   integer n_compared = 0;
   autoneg_page_registers i_dut (.i_core_clk(clk), .i_rst(rst), .i_reg_req(req), .o_reg_resp(resp),
      .i_rx_page(rx), .i_np_begin(nb), .i_np_first_toggle(nf), .i_np_sent(ns), .o_tx_page(tx));
   mgmt_host i_host (.i_core_clk(clk), .i_resp(resp), .o_req(req));
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input logic [15:0] a, input logic [15:0] e);
      i_host.rd_reg(a, d, ok);
      if (!ok) begin
         num_errors++;
         $display("mismatch read answer expected 1 seen 0");
         wrap_up();
      end else chk("read data", {32'h0, e}, {32'h0, d});
   endtask
   function automatic logic [47:0] exp_tx(input logic [15:0] a, b, c, input logic t);
      return {c, b, a[15], 1'b0, a[13:12], t, a[10:0]};
   endfunction
   task automatic cap(input logic [47:0] v);
      @(negedge clk);
      rx = '{valid: 1'b1, word: v};
      @(negedge clk);
      rx = '{valid: 1'b0, word: ~v};
   endtask
   // begin wins over sent in the same cycle
   task automatic np(input logic b, input logic f, input logic s);
      @(negedge clk);
      nb = b;
      nf = f;
      ns = s;
      @(negedge clk);
      nb = 0;
      ns = 0;
      tog = b ? f : (s ? ~tog : tog);
      chk("tx toggle", exp_tx(n0, n1, n2, tog), tx);
   endtask
   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial begin
      rst = 1;
      nb = 0;
      nf = 0;
      ns = 0;
      tog = 0;
      rx = '{valid: 1'b0, word: 48'h0};
      n0 = 16'h2000;
      n1 = 16'h0000;
      n2 = 16'h0000;
      repeat (12) @(negedge clk);
      rst = 0;
      chk("tx reset", exp_tx(n0, n1, n2, 1'b0), tx);
      rchk(autoneg_pkg::OFF_PARTNER_LOW, 16'h0001);
      rchk(autoneg_pkg::OFF_PARTNER_MID, 16'h0000);
      rchk(autoneg_pkg::OFF_PARTNER_HIGH, 16'h0000);
      rchk(autoneg_pkg::OFF_NP_LOW, 16'h2000);
      rchk(autoneg_pkg::OFF_NP_MID, 16'h0000);
      rchk(autoneg_pkg::OFF_NP_HIGH, 16'h0000);
      rchk(16'h0019, 16'h0000);
      for (int i = 0; i < 24; i++) begin
         w = (i == 0) ? 48'hFFFF_FFFF_FFFF : 48'({$random(seed), $random(seed)});
         cap(w);
         for (int k = 0; k < 3; k++) i_host.wr_reg(autoneg_pkg::OFF_PARTNER_LOW + 16'(k), 16'($random(seed)));
         rchk(autoneg_pkg::OFF_PARTNER_LOW, {w[15:5], 5'h01});
         cap(~w);
         rchk(autoneg_pkg::OFF_PARTNER_MID, w[31:16]);
         rchk(autoneg_pkg::OFF_PARTNER_HIGH, w[47:32]);
         n0 = 16'($random(seed));
         n1 = 16'($random(seed));
         n2 = 16'($random(seed));
         i_host.wr_reg(autoneg_pkg::OFF_NP_LOW, n0);
         i_host.wr_reg(autoneg_pkg::OFF_NP_MID, n1);
         i_host.wr_reg(autoneg_pkg::OFF_NP_HIGH, n2);
         chk("tx words", exp_tx(n0, n1, n2, tog), tx);
         rchk(autoneg_pkg::OFF_NP_LOW, n0 & 16'hBFFF);
         rchk(autoneg_pkg::OFF_NP_MID, n1);
         rchk(autoneg_pkg::OFF_NP_HIGH, n2);
         np(i % 4 < 2, 1'($random(seed)), i % 4 != 1);
      end
      // mid-run reset must bring back the reset values of the transmit page and the partner low, partner high and next-page low words over dirty state
      @(negedge clk);
      rst = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      tog = 0;
      n0 = 16'h2000;
      n1 = 16'h0000;
      n2 = 16'h0000;
      chk("tx after reset", exp_tx(n0, n1, n2, tog), tx);
      rchk(autoneg_pkg::OFF_PARTNER_LOW, 16'h0001);
      rchk(autoneg_pkg::OFF_PARTNER_HIGH, 16'h0000);
      rchk(autoneg_pkg::OFF_NP_LOW, 16'h2000);
      wrap_up();
   end
endmodule
`default_nettype wire
